// ==== wtm_consts.vh ====
// Operation
// - range bit picks 100 ms per step when 0, 10 ms per step when 1.
// - timeout equals one plus the 3-bit code, times the step.
// - timeout interrupt bit 3 raises an interrupt at every timer expiry.
// - amplitude bit 2 measures at timeout; irq when difference exceeds threshold.
// - phase bit 1 measures at timeout; irq when difference exceeds threshold.
// - capacitance bit 0 measures at timeout; irq when difference exceeds threshold.
// - amplitude threshold is bits 7 to 4 of amplitude config.
// - amplitude include bit decides whether interrupting sample enters the average.
// - weight code 00,01,10,11 gives 4,8,16,32 for newest sample.
// - amplitude select 0 compares against the amplitude reference register.
// - phase threshold is bits 7 to 4 of phase config.
// - phase include bit decides whether interrupting sample enters the average.
// - phase select 0 uses phase reference, 1 uses phase average.
// - amplitude reference is 8-bit read-write, zero after reset.
// - amplitude average is 8-bit read-only, zero after reset.
// - last amplitude result is 8-bit read-only, zero after reset.
// - phase reference is 8-bit read-write, zero after reset.
// - phase average is 8-bit read-only, zero after reset.
// - last phase result is 8-bit read-only, zero after reset.
`ifndef WTM_CONSTS_VH
`define WTM_CONSTS_VH

// ****************************************
// register indices, byte address is index times four
// ****************************************
`define WTM_IDX_TIMER_CTRL 6'h32
`define WTM_IDX_AMP_CFG 6'h33
`define WTM_IDX_AMP_REF 6'h34
`define WTM_IDX_AMP_AVG 6'h35
`define WTM_IDX_AMP_RES 6'h36
`define WTM_IDX_PH_CFG 6'h37
`define WTM_IDX_PH_REF 6'h38
`define WTM_IDX_PH_AVG 6'h39
`define WTM_IDX_PH_RES 6'h3A

// ****************************************
// field positions
// ****************************************
`define WTM_CTRL_RANGE 7
`define WTM_CTRL_CODE_HI 6
`define WTM_CTRL_CODE_LO 4
`define WTM_CTRL_TIMEOUT_IRQ 3
`define WTM_CTRL_AMP_EN 2
`define WTM_CTRL_PH_EN 1
`define WTM_CTRL_CAP_EN 0
`define WTM_CFG_THR_HI 7
`define WTM_CFG_THR_LO 4
`define WTM_CFG_INCLUDE 3
`define WTM_CFG_WEIGHT_HI 2
`define WTM_CFG_WEIGHT_LO 1
`define WTM_CFG_REF_SEL 0

// ****************************************
// reset values and bus answers
// ****************************************
`define WTM_RESET_BYTE 8'h00
`define WTM_RESP_OKAY 2'h0
`define WTM_RESP_SLVERR 2'h2

// ****************************************
// timing
// ****************************************
`define WTM_CLK_MHZ 100
`define WTM_STEP_SLOW_MS 100
`define WTM_STEP_FAST_MS 10
`define WTM_WEIGHT_SHIFT_BASE 2
`define WTM_STEP_SLOW_CYCLES 24'h989680
`define WTM_STEP_FAST_CYCLES 24'h0F4240

`endif

// ==== wtm_wakeup_timer.v ====
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "wtm_consts.vh"

module wtm_wakeup_timer #(
	parameter [23:0] STEP_SLOW_CYCLES = `WTM_STEP_SLOW_CYCLES,
	parameter [23:0] STEP_FAST_CYCLES = `WTM_STEP_FAST_CYCLES
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire amplitude_result_valid,
	input wire [7:0] amplitude_result_in,
	input wire phase_result_valid,
	input wire [7:0] phase_result_in,
	input wire capacitance_result_valid,
	input wire capacitance_over_threshold,
	output wire amplitude_measure_start,
	output wire phase_measure_start,
	output wire capacitance_measure_start,
	output wire timeout_irq,
	output wire amplitude_wake_irq,
	output wire phase_wake_irq,
	output wire capacitance_wake_irq
);

	// ****************************************
	// functions
	// ****************************************
	function [7:0] wtm_addr;
		input [5:0] idx;
		begin
			wtm_addr = {idx, 2'b00};
		end
	endfunction

	function [7:0] wtm_absdiff;
		input [7:0] a;
		input [7:0] b;
		begin
			wtm_absdiff = (a > b) ? (a - b) : (b - a);
		end
	endfunction

	function [7:0] wtm_average;
		input [7:0] avg;
		input [7:0] res;
		input [1:0] weight;
		reg signed [8:0] d;
		begin
			d = $signed({1'b0, res}) - $signed({1'b0, avg});
			d = d >>> (`WTM_WEIGHT_SHIFT_BASE + weight);
			wtm_average = avg + d[7:0];
		end
	endfunction

	function wtm_exceeds;
		input [7:0] res;
		input [7:0] ref_val;
		input [3:0] thr;
		begin
			wtm_exceeds = wtm_absdiff(res, ref_val) > {4'h0, thr};
		end
	endfunction

	// ****************************************
	// registers
	// ****************************************
	reg [7:0] ctrl_reg;
	reg [7:0] amp_cfg_reg;
	reg [7:0] amplitude_reference_value_reg;
	reg [7:0] amplitude_average_reg;
	reg [7:0] amplitude_result_value_reg;
	reg [7:0] ph_cfg_reg;
	reg [7:0] phase_reference_value_reg;
	reg [7:0] phase_average_value_reg;
	reg [7:0] phase_result_value_reg;

	reg awready_reg;
	reg wready_reg;
	reg aw_held_reg;
	reg w_held_reg;
	reg [7:0] awaddr_reg;
	reg [7:0] wdata_reg;
	reg wstrb0_reg;
	reg bvalid_reg;
	reg [1:0] bresp_reg;
	reg arready_reg;
	reg rvalid_reg;
	reg [31:0] rdata_reg;
	reg [1:0] rresp_reg;

	reg [23:0] step_cnt_reg;
	reg [2:0] step_idx_reg;
	reg amp_start_reg;
	reg ph_start_reg;
	reg cap_start_reg;
	reg timeout_irq_reg;
	reg amp_irq_reg;
	reg ph_irq_reg;
	reg cap_irq_reg;

	// ****************************************
	// inputs that carry nothing for this block
	// ****************************************
	wire unused_inputs = &{1'b0, s_axi_awprot, s_axi_arprot,
		s_axi_wdata[31:8], s_axi_wstrb[3:1]};

	// ****************************************
	// bus handshakes
	// ****************************************
	wire aw_hs = s_axi_awvalid & awready_reg;
	wire w_hs = s_axi_wvalid & wready_reg;
	wire do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
	wire ar_hs = s_axi_arvalid & arready_reg;
	wire aw_held_next = (aw_held_reg | aw_hs) & ~do_write;
	wire w_held_next = (w_held_reg | w_hs) & ~do_write;
	wire bvalid_next = do_write | (bvalid_reg & ~s_axi_bready);
	wire rvalid_next = ar_hs | (rvalid_reg & ~s_axi_rready);
	wire wr_en = do_write & wstrb0_reg;

	reg wr_hit;
	always @* begin
		case (awaddr_reg)
			wtm_addr(`WTM_IDX_TIMER_CTRL),
			wtm_addr(`WTM_IDX_AMP_CFG),
			wtm_addr(`WTM_IDX_AMP_REF),
			wtm_addr(`WTM_IDX_AMP_AVG),
			wtm_addr(`WTM_IDX_AMP_RES),
			wtm_addr(`WTM_IDX_PH_CFG),
			wtm_addr(`WTM_IDX_PH_REF),
			wtm_addr(`WTM_IDX_PH_AVG),
			wtm_addr(`WTM_IDX_PH_RES): wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	reg [7:0] rd_byte;
	reg rd_hit;
	always @* begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			wtm_addr(`WTM_IDX_TIMER_CTRL): rd_byte = ctrl_reg;
			wtm_addr(`WTM_IDX_AMP_CFG): rd_byte = amp_cfg_reg;
			wtm_addr(`WTM_IDX_AMP_REF): rd_byte = amplitude_reference_value_reg;
			wtm_addr(`WTM_IDX_AMP_AVG): rd_byte = amplitude_average_reg;
			wtm_addr(`WTM_IDX_AMP_RES): rd_byte = amplitude_result_value_reg;
			wtm_addr(`WTM_IDX_PH_CFG): rd_byte = ph_cfg_reg;
			wtm_addr(`WTM_IDX_PH_REF): rd_byte = phase_reference_value_reg;
			wtm_addr(`WTM_IDX_PH_AVG): rd_byte = phase_average_value_reg;
			wtm_addr(`WTM_IDX_PH_RES): rd_byte = phase_result_value_reg;
			default: begin
				rd_byte = `WTM_RESET_BYTE;
				rd_hit = 1'b0;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `WTM_RESP_OKAY;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			awready_reg <= ~aw_held_next & ~bvalid_next;
			wready_reg <= ~w_held_next & ~bvalid_next;
			bvalid_reg <= bvalid_next;
			if (aw_hs) begin
				awaddr_reg <= s_axi_awaddr;
			end
			if (w_hs) begin
				wdata_reg <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
			end
			if (do_write) begin
				bresp_reg <= wr_hit ? `WTM_RESP_OKAY : `WTM_RESP_SLVERR;
			end
		end
	end

	// ****************************************
	// read channel
	// ****************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `WTM_RESP_OKAY;
		end else begin
			arready_reg <= ~rvalid_next;
			rvalid_reg <= rvalid_next;
			if (ar_hs) begin
				rdata_reg <= {24'h000000, rd_byte};
				rresp_reg <= rd_hit ? `WTM_RESP_OKAY : `WTM_RESP_SLVERR;
			end
		end
	end

	// ****************************************
	// wake-up timer
	// ****************************************
	wire timer_run = |ctrl_reg[`WTM_CTRL_TIMEOUT_IRQ:`WTM_CTRL_CAP_EN];
	wire ctrl_write = wr_en & (awaddr_reg == wtm_addr(`WTM_IDX_TIMER_CTRL));
	wire [23:0] step_limit = ctrl_reg[`WTM_CTRL_RANGE] ?
		STEP_FAST_CYCLES : STEP_SLOW_CYCLES;
	wire step_done = (step_cnt_reg == step_limit - 24'h000001);
	wire expire = timer_run & step_done &
		(step_idx_reg == ctrl_reg[`WTM_CTRL_CODE_HI:`WTM_CTRL_CODE_LO]);

	reg [23:0] step_cnt_next;
	reg [2:0] step_idx_next;
	always @* begin
		step_cnt_next = step_cnt_reg + 24'h000001;
		step_idx_next = step_idx_reg;
		if (!timer_run || ctrl_write) begin
			step_cnt_next = 24'h000000;
			step_idx_next = 3'h0;
		end else if (step_done) begin
			step_cnt_next = 24'h000000;
			step_idx_next = expire ? 3'h0 : step_idx_reg + 3'h1;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			step_cnt_reg <= 24'h000000;
			step_idx_reg <= 3'h0;
		end else begin
			step_cnt_reg <= step_cnt_next;
			step_idx_reg <= step_idx_next;
		end
	end

	// ****************************************
	// measurement evaluation
	// ****************************************
	wire [7:0] amp_ref = amp_cfg_reg[`WTM_CFG_REF_SEL] ?
		amplitude_average_reg : amplitude_reference_value_reg;
	wire amp_hit = wtm_exceeds(amplitude_result_in, amp_ref,
		amp_cfg_reg[`WTM_CFG_THR_HI:`WTM_CFG_THR_LO]);
	wire amp_avg_upd = ~amp_hit | amp_cfg_reg[`WTM_CFG_INCLUDE];
	wire [7:0] ph_ref = ph_cfg_reg[`WTM_CFG_REF_SEL] ?
		phase_average_value_reg : phase_reference_value_reg;
	wire ph_hit = wtm_exceeds(phase_result_in, ph_ref,
		ph_cfg_reg[`WTM_CFG_THR_HI:`WTM_CFG_THR_LO]);
	wire ph_avg_upd = ~ph_hit | ph_cfg_reg[`WTM_CFG_INCLUDE];

	// ****************************************
	// configuration registers
	// ****************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= `WTM_RESET_BYTE;
			amp_cfg_reg <= `WTM_RESET_BYTE;
			amplitude_reference_value_reg <= `WTM_RESET_BYTE;
			ph_cfg_reg <= `WTM_RESET_BYTE;
			phase_reference_value_reg <= `WTM_RESET_BYTE;
		end else if (wr_en) begin
			case (awaddr_reg)
				wtm_addr(`WTM_IDX_TIMER_CTRL): ctrl_reg <= wdata_reg;
				wtm_addr(`WTM_IDX_AMP_CFG): amp_cfg_reg <= wdata_reg;
				wtm_addr(`WTM_IDX_AMP_REF):
					amplitude_reference_value_reg <= wdata_reg;
				wtm_addr(`WTM_IDX_PH_CFG): ph_cfg_reg <= wdata_reg;
				wtm_addr(`WTM_IDX_PH_REF):
					phase_reference_value_reg <= wdata_reg;
				default: ctrl_reg <= ctrl_reg;
			endcase
		end
	end

	// ****************************************
	// event pulses
	// ****************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			amp_start_reg <= 1'b0;
			ph_start_reg <= 1'b0;
			cap_start_reg <= 1'b0;
			timeout_irq_reg <= 1'b0;
			amp_irq_reg <= 1'b0;
			ph_irq_reg <= 1'b0;
			cap_irq_reg <= 1'b0;
		end else begin
			timeout_irq_reg <= expire & ctrl_reg[`WTM_CTRL_TIMEOUT_IRQ];
			amp_start_reg <= expire & ctrl_reg[`WTM_CTRL_AMP_EN];
			ph_start_reg <= expire & ctrl_reg[`WTM_CTRL_PH_EN];
			cap_start_reg <= expire & ctrl_reg[`WTM_CTRL_CAP_EN];
			amp_irq_reg <= amplitude_result_valid & amp_hit;
			ph_irq_reg <= phase_result_valid & ph_hit;
			cap_irq_reg <= capacitance_result_valid &
				capacitance_over_threshold;
		end
	end

	// ****************************************
	// amplitude result and average
	// ****************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			amplitude_average_reg <= `WTM_RESET_BYTE;
			amplitude_result_value_reg <= `WTM_RESET_BYTE;
		end else if (amplitude_result_valid) begin
			amplitude_result_value_reg <= amplitude_result_in;
			if (amp_avg_upd) begin
				amplitude_average_reg <= wtm_average(amplitude_average_reg,
					amplitude_result_in,
					amp_cfg_reg[`WTM_CFG_WEIGHT_HI:`WTM_CFG_WEIGHT_LO]);
			end
		end
	end

	// ****************************************
	// phase result and average
	// ****************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			phase_average_value_reg <= `WTM_RESET_BYTE;
			phase_result_value_reg <= `WTM_RESET_BYTE;
		end else if (phase_result_valid) begin
			phase_result_value_reg <= phase_result_in;
			if (ph_avg_upd) begin
				phase_average_value_reg <= wtm_average(phase_average_value_reg,
					phase_result_in,
					ph_cfg_reg[`WTM_CFG_WEIGHT_HI:`WTM_CFG_WEIGHT_LO]);
			end
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign amplitude_measure_start = amp_start_reg;
	assign phase_measure_start = ph_start_reg;
	assign capacitance_measure_start = cap_start_reg;
	assign timeout_irq = timeout_irq_reg;
	assign amplitude_wake_irq = amp_irq_reg;
	assign phase_wake_irq = ph_irq_reg;
	assign capacitance_wake_irq = cap_irq_reg;

endmodule

// ==== wtm_wakeup_timer_props.sv ====
`timescale 1ns/1ps
// ****************
// port checks
// ****************
module wtm_props #(
	parameter [23:0] STEP_SLOW_CYCLES = 24'h14,
	parameter [23:0] STEP_FAST_CYCLES = 24'h5
) (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire amplitude_result_valid,
	input wire phase_result_valid,
	input wire capacitance_result_valid,
	input wire capacitance_over_threshold,
	input wire timeout_irq,
	input wire amplitude_wake_irq,
	input wire phase_wake_irq,
	input wire capacitance_wake_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wr_answer;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
		else $error("write answer late");
	a_write_refused: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready) else $error("write not refused");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read answer late");
	a_timeout_pulse: assert property (timeout_irq |=> !timeout_irq [*4])
		else $error("timeout too soon");
	a_amp_cause: assert property (amplitude_wake_irq |->
		$past(amplitude_result_valid)) else $error("amp irq uncaused");
	a_phase_cause: assert property (phase_wake_irq |->
		$past(phase_result_valid)) else $error("phase irq uncaused");
	a_cap_irq: assert property (capacitance_result_valid &&
		capacitance_over_threshold |=> capacitance_wake_irq)
		else $error("cap irq missing");
endmodule

bind wtm_wakeup_timer wtm_props #(
	.STEP_SLOW_CYCLES(STEP_SLOW_CYCLES),
	.STEP_FAST_CYCLES(STEP_FAST_CYCLES)
) u_props (.*);

// ==== wtm_wakeup_timer_tb.sv ====
`timescale 1ns/1ps
module wtm_wakeup_timer_tb;
	reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	reg s_axi_arvalid, s_axi_rready, amplitude_result_valid;
	reg phase_result_valid, capacitance_result_valid;
	reg capacitance_over_threshold;
	reg [7:0] s_axi_awaddr, s_axi_araddr, amplitude_result_in, phase_result_in;
	reg [31:0] s_axi_wdata, rdat;
	reg [3:0] s_axi_wstrb;
	reg [2:0] s_axi_awprot, s_axi_arprot, cv;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire amplitude_measure_start, phase_measure_start, capacitance_measure_start;
	wire timeout_irq, amplitude_wake_irq, phase_wake_irq, capacitance_wake_irq;
	reg [7:0] c, rf, v, a;
	reg [1:0] rrs;
	reg ch, irq;
	integer seed;
	int errors, checks_done, i, n, d, re;
	int avgv [0:1];

	wtm_wakeup_timer #(
		.STEP_SLOW_CYCLES(24'h14),
		.STEP_FAST_CYCLES(24'h5)
	) dut (.*);

	always #5 aclk = ~aclk;

	// ****************
	// helpers
	// ****************
	task chk(input [31:0] seen, input [31:0] exp, input [63:0] nm);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("wrong value %0s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask

	function int avg_next(input int p, input int q, input int w);
		avg_next = p + ((q - p) >>> (w + 2));
	endfunction

	task wr(input [7:0] ad, input [7:0] dv, input [1:0] er);
		reg ta, tw, tb, t;
		begin
			@(posedge aclk);
			s_axi_awaddr <= ad;
			s_axi_wdata <= {24'h0, dv};
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			t = 0;
			while (!t) begin
				@(negedge aclk);
				ta = s_axi_awready;
				tw = s_axi_wready;
				tb = s_axi_bvalid;
				t = tb && s_axi_bready;
				rrs = s_axi_bresp;
				@(posedge aclk);
				if (ta) s_axi_awvalid <= 1'h0;
				if (tw) s_axi_wvalid <= 1'h0;
				s_axi_bready <= tb && !t;
			end
			chk(rrs, er, "bresp");
		end
	endtask

	task rd(input [7:0] ad, input [1:0] er);
		reg ta, tv, t;
		begin
			@(posedge aclk);
			s_axi_araddr <= ad;
			s_axi_arvalid <= 1'h1;
			t = 0;
			while (!t) begin
				@(negedge aclk);
				ta = s_axi_arready;
				tv = s_axi_rvalid;
				t = tv && s_axi_rready;
				rdat = s_axi_rdata;
				rrs = s_axi_rresp;
				@(posedge aclk);
				if (ta) s_axi_arvalid <= 1'h0;
				s_axi_rready <= tv && !t;
			end
			chk(rrs, er, "rresp");
		end
	endtask

	task finish_test;
		begin
			$display("checks %0d errors %0d", checks_done, errors);
			if (errors == 0 && checks_done > 0) begin
				$display("NO MISMATCHES");
			end else begin
				$display("MISMATCHES SEEN");
			end
			$finish;
		end
	endtask

	initial begin
		#400000;
		errors = errors + 1;
		finish_test;
	end

	// ****************
	// tests
	// ****************
	initial begin
		seed = 88866;
		aclk = 1'h0;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, amplitude_result_valid} = 3'h0;
		{phase_result_valid, capacitance_result_valid} = 2'h0;
		capacitance_over_threshold = 1'h0;
		{s_axi_awaddr, s_axi_araddr} = 16'h0;
		{amplitude_result_in, phase_result_in} = 16'h0;
		{s_axi_awprot, s_axi_arprot} = 6'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		wr(8'hD4, 8'hFF, 2'h0);
		wr(8'h00, 8'h5A, 2'h2);
		for (i = 0; i < 9; i = i + 1) begin
			rd(8'hC8 + 4 * i, 2'h0);
			chk(rdat, 0, "reset");
		end
		rd(8'hF0, 2'h2);
		chk(rdat, 0, "unmap");
		$display("register test done");
		for (i = 0; i < 4; i = i + 1) begin
			c = {i[0], 7'h08} | ($random(seed) & 8'h77);
			wr(8'hC8, c, 2'h0);
			@(negedge aclk);
			while (!timeout_irq) @(negedge aclk);
			chk({amplitude_measure_start, phase_measure_start,
				capacitance_measure_start}, c[2:0], "start");
			n = 0;
			do begin
				@(negedge aclk);
				n = n + 1;
			end while (!timeout_irq);
			chk(n, (c[6:4] + 1) * (c[7] ? 5 : 20), "period");
		end
		wr(8'hC8, 8'h00, 2'h0);
		$display("timer test done");
		for (i = 0; i < 30; i = i + 1) begin
			ch = $random(seed);
			c = $random(seed);
			rf = $random(seed);
			cv = $random(seed);
			re = c[0] ? avgv[ch] : rf;
			v = re + $random(seed) % 24;
			if (i < 2) begin
				c[7:4] = 4'h3;
				v = re + 3 + i;
			end
			a = ch ? 8'hDC : 8'hCC;
			wr(a, c, 2'h0);
			wr(a + 4, rf, 2'h0);
			rd(a + 4, 2'h0);
			chk(rdat, rf, "ref");
			@(posedge aclk);
			amplitude_result_valid <= !ch;
			phase_result_valid <= ch;
			amplitude_result_in <= v;
			phase_result_in <= v;
			capacitance_result_valid <= cv[0];
			capacitance_over_threshold <= cv[1];
			@(posedge aclk);
			amplitude_result_valid <= 1'h0;
			phase_result_valid <= 1'h0;
			capacitance_result_valid <= 1'h0;
			@(negedge aclk);
			d = v - re;
			if (d < 0) d = -d;
			irq = d > c[7:4];
			chk(ch ? phase_wake_irq : amplitude_wake_irq, irq, "wake");
			chk(capacitance_wake_irq, cv[0] & cv[1], "cap");
			if (!irq || c[3]) avgv[ch] = avg_next(avgv[ch], v, c[2:1]);
			rd(a + 8, 2'h0);
			chk(rdat, avgv[ch], "avg");
			rd(a + 12, 2'h0);
			chk(rdat, v, "res");
		end
		$display("measure test done");
		finish_test;
	end
endmodule
